/* File: logic/mis_pkg.sv */
package mis_pkg;
  // ***********************
  // register map
  // ***********************
  localparam logic [7:0] MIS_ADDR_CMD = 8'h00;
  localparam logic [7:0] MIS_ADDR_ACC = 8'h04;
  localparam logic [7:0] MIS_ADDR_STATUS = 8'h08;
  localparam logic [7:0] MIS_ADDR_PC = 8'h0c;
  localparam logic [7:0] MIS_ADDR_MEM = 8'h10;
  localparam logic [7:0] MIS_ADDR_STACK = 8'h14;
  localparam logic [7:0] MIS_ADDR_WDT = 8'h18;
  // ***********************
  // command fields
  // ***********************
  localparam int MIS_CMD_OP_LSB = 0;
  localparam int MIS_CMD_BIT_LSB = 8;
  localparam int MIS_CMD_IMM_LSB = 16;
  // ***********************
  // status bit positions
  // ***********************
  localparam int MIS_ST_C = 0;
  localparam int MIS_ST_AC = 1;
  localparam int MIS_ST_Z = 2;
  localparam int MIS_ST_PDF = 3;
  localparam int MIS_ST_TO = 4;
  localparam int MIS_ST_GIE = 5;
  localparam int MIS_ST_BUSY = 6;
  localparam int MIS_ST_PRE1 = 7;
  localparam int MIS_ST_PRE2 = 8;
  // ***********************
  // reset values and timing
  // ***********************
  localparam logic [7:0] MIS_BYTE_ZERO = 8'h00;
  localparam logic [11:0] MIS_PC_RESET = 12'h000;
  localparam logic [3:0] MIS_BCD_ADJ = 4'h6;
  localparam logic [4:0] MIS_BCD_MAX = 5'h09;
  localparam logic [3:0] MIS_CYCLE_CLKS = 4'h4;
  localparam logic [3:0] MIS_LONG_CLKS = 4'h8;
  localparam logic [1:0] MIS_RESP_OKAY = 2'b00;
  localparam logic [1:0] MIS_RESP_SLVERR = 2'b10;
  typedef enum logic [4:0] {
    MIS_OP_NOP, MIS_OP_CLR, MIS_OP_CLR_BIT, MIS_OP_WDT_CLR, MIS_OP_WDT_PRE1,
    MIS_OP_WDT_PRE2, MIS_OP_CPL, MIS_OP_COMPLEMENT_TO_ACC_OP, MIS_OP_DAA, MIS_OP_DEC,
    MIS_OP_DECREMENT_TO_ACC_OP, MIS_OP_INC, MIS_OP_INCREMENT_TO_ACC_OP, MIS_OP_HALT, MIS_OP_JMP,
    MIS_OP_MOV_AM, MIS_OP_MOV_MA, MIS_OP_MOV_AX, MIS_OP_OR_AM, MIS_OP_OR_AX,
    MIS_OP_ORM, MIS_OP_RET, MIS_OP_RET_AX, MIS_OP_INTERRUPT_RETURN_OP
  } mis_op_t;
endpackage

/* File: logic/mis_core.sv */
// Functional notes
// [RL1] clear writes zero byte, flags untouched
// [RL2] clear bit zeroes one selected bit
// [RL3] watchdog clear zeroes counter, power-down, timeout
// [RL4] both pre-clears together clear watchdog and flags
// [RL5] single pre-clear only records it ran
// [RL6] complement memory in place, zero flag
// [RL7] complement into accumulator, memory kept
// [RL8] decimal adjust low nibble plus six
// [RL9] decimal adjust high nibble, carry only
// [RL10] decrement to memory or accumulator, zero flag
// [RL11] increment to memory or accumulator, zero flag
// [RL12] power-down stops execution, pc plus one
// [RL13] power-down clears watchdog, sets power-down flag
// [RL14] jump loads pc from instruction
// [RL15] moves copy data, no flags
// [RL16] no-op only advances pc
// [RL17] or into accumulator, zero flag
// [RL18] or into memory, zero flag
// [RL19] return reloads pc, two cycles
// [RL20] return with value loads accumulator
// [RL21] interrupt return sets global interrupt enable
// [RL22] pc load costs extra four-clock cycle
// [RL23] zero flag set when result zero
`timescale 1ns/100ps
module mis_core
  import mis_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic wake,
  output logic clock_stopped
);
  import mis_pkg::*;

  typedef struct packed {
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] acc;
    logic [7:0] mem;
    logic [11:0] pc;
    logic [11:0] stack;
    logic [7:0] wdt;
    logic c;
    logic ac;
    logic z;
    logic power_down_flag;
    logic to;
    logic gie;
    logic pre1;
    logic pre2;
    logic halted;
    logic [3:0] busy;
  } mis_state_t;

  mis_state_t s_q;
  mis_state_t s_d;
  logic wr_fire;
  logic busy;
  logic [31:0] status_word;
  mis_op_t op;
  logic [2:0] bsel;
  logic [7:0] imm;
  logic [11:0] addr;
  logic [7:0] res;
  logic upd_z;
  logic [4:0] lo_sum;
  logic [4:0] hi_sum;
  logic ac1;
  logic [31:0] merged;

  assign busy = (s_q.busy != 4'h0);
  assign status_word = {23'h000000, s_q.pre2, s_q.pre1, busy, s_q.gie, s_q.to,
                        s_q.power_down_flag, s_q.z, s_q.ac, s_q.c};
  assign wr_fire = s_q.aw_got && s_q.w_got && !s_q.bvalid;
  assign merged = {s_q.w_strb[3] ? s_q.w_data[31:24] : 8'h00,
                   s_q.w_strb[2] ? s_q.w_data[23:16] : 8'h00,
                   s_q.w_strb[1] ? s_q.w_data[15:8] : 8'h00,
                   s_q.w_strb[0] ? s_q.w_data[7:0] : 8'h00};
  assign op = mis_op_t'(merged[MIS_CMD_OP_LSB +: 5]);
  assign bsel = merged[MIS_CMD_BIT_LSB +: 3];
  assign imm = merged[MIS_CMD_IMM_LSB +: 8];
  assign addr = merged[MIS_CMD_IMM_LSB +: 12];

  // ***********************
  // decimal adjust
  // ***********************
  always_comb begin
    // [RL8] low nibble adjust
    if ({1'b0, s_q.acc[3:0]} > MIS_BCD_MAX || s_q.ac) begin
      lo_sum = {1'b0, s_q.acc[3:0]} + {1'b0, MIS_BCD_ADJ};
      ac1 = !s_q.ac;
    end else begin
      lo_sum = {1'b0, s_q.acc[3:0]};
      ac1 = 1'b0;
    end
    // [RL9] high nibble with internal carry
    hi_sum = {1'b0, s_q.acc[7:4]} + {4'h0, ac1};
    if (hi_sum > MIS_BCD_MAX || s_q.c) begin
      hi_sum = hi_sum + {1'b0, MIS_BCD_ADJ};
    end
  end

  // ***********************
  // next state
  // ***********************
  always_comb begin
    s_d = s_q;
    res = MIS_BYTE_ZERO;
    upd_z = 1'b0;
    if (s_q.busy != 4'h0) begin
      s_d.busy = s_q.busy - 4'h1;
    end
    if (s_q.halted && wake) begin
      s_d.halted = 1'b0;
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
    end
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (wr_fire) begin
      s_d.bvalid = 1'b1;
      s_d.bresp = MIS_RESP_OKAY;
      case (s_q.aw_addr)
        MIS_ADDR_CMD: begin
          if (busy || s_q.halted) begin
            s_d.bresp = MIS_RESP_SLVERR;
          end else begin
            // [RL16] one cycle per instruction, two for jump and returns
            s_d.pc = s_q.pc + 12'h001;
            s_d.busy = MIS_CYCLE_CLKS - 4'h1;
            case (op)
              MIS_OP_NOP: begin
              end
              // [RL1] clear byte
              MIS_OP_CLR: s_d.mem = MIS_BYTE_ZERO;
              // [RL2] clear single bit
              MIS_OP_CLR_BIT: s_d.mem[bsel] = 1'b0;
              MIS_OP_WDT_CLR, MIS_OP_WDT_PRE1, MIS_OP_WDT_PRE2: begin
                // [RL3] [RL4] full clear or completed pair
                if (op == MIS_OP_WDT_CLR || (op == MIS_OP_WDT_PRE1 && s_q.pre2) ||
                    (op == MIS_OP_WDT_PRE2 && s_q.pre1)) begin
                  s_d.wdt = MIS_BYTE_ZERO;
                  s_d.power_down_flag = 1'b0;
                  s_d.to = 1'b0;
                  s_d.pre1 = 1'b0;
                  s_d.pre2 = 1'b0;
                // [RL5] only note it ran
                end else if (op == MIS_OP_WDT_PRE1) begin
                  s_d.pre1 = 1'b1;
                end else begin
                  s_d.pre2 = 1'b1;
                end
              end
              // [RL6] complement in place
              MIS_OP_CPL: begin
                res = ~s_q.mem;
                s_d.mem = res;
                upd_z = 1'b1;
              end
              // [RL7] complement into accumulator
              MIS_OP_COMPLEMENT_TO_ACC_OP: begin
                res = ~s_q.mem;
                s_d.acc = res;
                upd_z = 1'b1;
              end
              // [RL9] result to memory, only carry flag may change
              MIS_OP_DAA: begin
                s_d.mem = {hi_sum[3:0], lo_sum[3:0]};
                if ({1'b0, s_q.acc[7:4]} + {4'h0, ac1} > MIS_BCD_MAX || s_q.c) begin
                  s_d.c = 1'b1;
                end
              end
              // [RL10] [RL11] step by one
              MIS_OP_DEC, MIS_OP_DECREMENT_TO_ACC_OP, MIS_OP_INC, MIS_OP_INCREMENT_TO_ACC_OP: begin
                res = (op == MIS_OP_INC || op == MIS_OP_INCREMENT_TO_ACC_OP) ? s_q.mem + 8'h01 : s_q.mem - 8'h01;
                if (op == MIS_OP_DEC || op == MIS_OP_INC) s_d.mem = res;
                else s_d.acc = res;
                upd_z = 1'b1;
              end
              // [RL12] [RL13] enter power-down
              MIS_OP_HALT: begin
                s_d.halted = 1'b1;
                s_d.wdt = MIS_BYTE_ZERO;
                s_d.power_down_flag = 1'b1;
                s_d.to = 1'b0;
              end
              // [RL14] [RL22] jump, extra cycle
              MIS_OP_JMP: begin
                s_d.pc = addr;
                s_d.busy = MIS_LONG_CLKS - 4'h1;
              end
              // [RL15] moves
              MIS_OP_MOV_AM: s_d.acc = s_q.mem;
              MIS_OP_MOV_MA: s_d.mem = s_q.acc;
              MIS_OP_MOV_AX: s_d.acc = imm;
              // [RL17] or into accumulator
              MIS_OP_OR_AM, MIS_OP_OR_AX: begin
                res = s_q.acc | ((op == MIS_OP_OR_AM) ? s_q.mem : imm);
                s_d.acc = res;
                upd_z = 1'b1;
              end
              // [RL18] or into memory
              MIS_OP_ORM: begin
                res = s_q.acc | s_q.mem;
                s_d.mem = res;
                upd_z = 1'b1;
              end
              // [RL19] [RL20] [RL21] returns, two cycles
              MIS_OP_RET, MIS_OP_RET_AX, MIS_OP_INTERRUPT_RETURN_OP: begin
                s_d.pc = s_q.stack;
                s_d.busy = MIS_LONG_CLKS - 4'h1;
                if (op == MIS_OP_RET_AX) s_d.acc = imm;
                if (op == MIS_OP_INTERRUPT_RETURN_OP) s_d.gie = 1'b1;
              end
              default: s_d.bresp = MIS_RESP_SLVERR;
            endcase
            // [RL23] zero flag from result
            if (upd_z) s_d.z = (res == MIS_BYTE_ZERO);
          end
        end
        MIS_ADDR_ACC: s_d.acc = merged[7:0];
        MIS_ADDR_MEM: s_d.mem = merged[7:0];
        MIS_ADDR_STACK: s_d.stack = merged[11:0];
        MIS_ADDR_WDT: s_d.wdt = merged[7:0];
        MIS_ADDR_STATUS: begin
          s_d.c = merged[MIS_ST_C];
          s_d.ac = merged[MIS_ST_AC];
          s_d.z = merged[MIS_ST_Z];
          s_d.gie = merged[MIS_ST_GIE];
        end
        MIS_ADDR_PC: s_d.pc = merged[11:0];
        default: s_d.bresp = MIS_RESP_SLVERR;
      endcase
    end
  end

  // ***********************
  // bus capture and read
  // ***********************
  assign s_axi_awready = !s_q.aw_got;
  assign s_axi_wready = !s_q.w_got;
  assign s_axi_arready = !s_q.rvalid;

  mis_state_t s_b;
  always_comb begin
    s_b = s_d;
    if (s_axi_awvalid && !s_q.aw_got) begin
      s_b.aw_got = 1'b1;
      s_b.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_q.w_got) begin
      s_b.w_got = 1'b1;
      s_b.w_data = s_axi_wdata;
      s_b.w_strb = s_axi_wstrb;
    end
    if (s_axi_arvalid && !s_q.rvalid) begin
      s_b.rvalid = 1'b1;
      s_b.rresp = MIS_RESP_OKAY;
      case (s_axi_araddr)
        MIS_ADDR_CMD: s_b.rdata = 32'h00000000;
        MIS_ADDR_ACC: s_b.rdata = {24'h000000, s_q.acc};
        MIS_ADDR_STATUS: s_b.rdata = status_word;
        MIS_ADDR_PC: s_b.rdata = {20'h00000, s_q.pc};
        MIS_ADDR_MEM: s_b.rdata = {24'h000000, s_q.mem};
        MIS_ADDR_STACK: s_b.rdata = {20'h00000, s_q.stack};
        MIS_ADDR_WDT: s_b.rdata = {24'h000000, s_q.wdt};
        default: begin
          s_b.rdata = 32'h00000000;
          s_b.rresp = MIS_RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_b;
    end
  end

  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign clock_stopped = s_q.halted;

  // ***********************
  // checks
  // ***********************
  property p_clr;
    @(posedge mclk) disable iff (reset)
      wr_fire && s_q.aw_addr == MIS_ADDR_CMD && !busy && !s_q.halted && op == MIS_OP_CLR
      |=> s_q.mem == 8'h00 && $stable({s_q.c, s_q.z, s_q.ac, s_q.power_down_flag, s_q.to});
  endproperty
  a_clr: assert property (p_clr) else $error("clear failed"); // [RL1]
  property p_wdt;
    @(posedge mclk) disable iff (reset)
      wr_fire && s_q.aw_addr == MIS_ADDR_CMD && !busy && !s_q.halted && op == MIS_OP_WDT_CLR
      |=> !s_q.power_down_flag && !s_q.to && s_q.wdt == 8'h00;
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog clear failed"); // [RL3]
  property p_pre;
    @(posedge mclk) disable iff (reset)
      wr_fire && s_q.aw_addr == MIS_ADDR_CMD && !busy && !s_q.halted &&
      op == MIS_OP_WDT_PRE1 && !s_q.pre2 |=> s_q.pre1 && $stable(s_q.power_down_flag) && $stable(s_q.to);
  endproperty
  a_pre: assert property (p_pre) else $error("single preclear changed flags"); // [RL5]
  property p_halt;
    @(posedge mclk) disable iff (reset)
      wr_fire && s_q.aw_addr == MIS_ADDR_CMD && !busy && !s_q.halted && op == MIS_OP_HALT
      |=> s_q.power_down_flag && !s_q.to && s_q.halted && s_q.pc == $past(s_q.pc) + 12'h001;
  endproperty
  a_halt: assert property (p_halt) else $error("halt failed"); // [RL13]
  property p_jmp;
    @(posedge mclk) disable iff (reset)
      wr_fire && s_q.aw_addr == MIS_ADDR_CMD && !busy && !s_q.halted && op == MIS_OP_JMP
      |=> s_q.pc == $past(addr) ##0 busy [*7] ##1 !busy;
  endproperty
  a_jmp: assert property (p_jmp) else $error("jump timing wrong"); // [RL22]
  property p_z;
    @(posedge mclk) disable iff (reset)
      wr_fire && s_q.aw_addr == MIS_ADDR_CMD && !busy && !s_q.halted && op == MIS_OP_INCREMENT_TO_ACC_OP
      |=> s_q.z == (s_q.acc == 8'h00) && s_q.acc == $past(s_q.mem) + 8'h01;
  endproperty
  a_z: assert property (p_z) else $error("increment zero flag wrong"); // [RL23]
  property p_interrupt_return_op;
    @(posedge mclk) disable iff (reset)
      wr_fire && s_q.aw_addr == MIS_ADDR_CMD && !busy && !s_q.halted && op == MIS_OP_INTERRUPT_RETURN_OP
      |=> s_q.gie && s_q.pc == $past(s_q.stack);
  endproperty
  a_interrupt_return_op: assert property (p_interrupt_return_op) else $error("interrupt return failed"); // [RL21]
  property p_orm;
    @(posedge mclk) disable iff (reset)
      wr_fire && s_q.aw_addr == MIS_ADDR_CMD && !busy && !s_q.halted && op == MIS_OP_ORM
      |=> s_q.mem == ($past(s_q.acc) | $past(s_q.mem)) && $stable(s_q.acc);
  endproperty
  a_orm: assert property (p_orm) else $error("or to memory failed"); // [RL18]
endmodule

/* File: test/test_mis_core.sv */
`timescale 1ns/100ps
module test_mis_core;
  import mis_pkg::*;
  // ***********************
  // signals and bench state
  // ***********************
  logic mclk = 1'b0, reset = 1'b1, wake = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awready, wready, bvalid, arready, rvalid, clock_stopped;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, rq;
  logic [31:0] seed = 32'h13e34bd3;
  logic [7:0] acc, mem, wdt;
  logic [11:0] pc, stk;
  logic c, ac, z, power_down_flag, to, gie, p1, p2;
  int errors = 0, checks_done = 0;
  typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} mis_note_t;
  mis_note_t notes[$];

  mis_core mis_core_inst (
    .mclk(mclk), .reset(reset), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .wake(wake), .clock_stopped(clock_stopped)
  );

  always #50 mclk = ~mclk;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // ***********************
  // report and compare
  // ***********************
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic tmo();
    errors++;
    $display("ERROR at %0t: wait ran out", $time);
    wrap_up();
  endtask

  task automatic cmp_data(input logic [31:0] e, input logic [31:0] g, input logic [31:0] m);
    checks_done++;
    if ((g & m) !== (e & m)) begin
      errors++;
      $display("ERROR at %0t: read %h expected %h", $time, g & m, e & m);
    end
  endtask

  task automatic cmp_resp(input logic [1:0] e, input logic [1:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("ERROR at %0t: resp %b expected %b", $time, g, e);
    end
  endtask

  // oldest note against each answer
  always @(posedge mclk) begin
    mis_note_t n;
    if ((rvalid && rready) || (bvalid && bready)) begin
      if (notes.size() == 0) begin
        cmp_resp(2'bxx, 2'b00);
      end else begin
        n = notes.pop_front();
        if (rvalid && rready) begin
          cmp_resp(n.r, rresp);
          if (n.m != 32'h0) cmp_data(n.d, rdata, n.m);
        end else begin
          cmp_resp(n.r, bresp);
        end
      end
    end
  end

  // ***********************
  // bus tasks
  // ***********************
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    logic ad;
    logic wd;
    notes.push_back('{d: 32'h0, m: 32'h0, r: r});
    ad = 1'b0;
    wd = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (n = 0; n < 40 && !(ad && wd); n++) begin
      @(posedge mclk);
      if (awvalid && awready) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    if (!(ad && wd)) tmo();
    bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge mclk);
      if (bvalid === 1'b1) break;
    end
    bready <= 1'b0;
    if (n == 40) tmo();
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                    input logic [1:0] r);
    int n;
    notes.push_back('{d: e, m: m, r: r});
    araddr <= a;
    arvalid <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge mclk);
      if (rready && rvalid === 1'b1) break;
      if (arvalid && arready) begin
        arvalid <= 1'b0;
        rready <= 1'b1;
      end
    end
    rq = rdata;
    rready <= 1'b0;
    if (n == 40) tmo();
  endtask

  task automatic wait_cs(input logic v);
    int n;
    for (n = 0; n < 40 && clock_stopped !== v; n++) @(posedge mclk);
    if (n == 40) tmo();
  endtask

  // ***********************
  // reference behaviour
  // ***********************
  task automatic model(input logic [4:0] op, input logic [2:0] bt, input logic [11:0] im);
    logic [3:0] lo;
    logic [4:0] hi;
    logic a1;
    pc = pc + 12'h001;
    case (op)
      MIS_OP_CLR: mem = 8'h00;
      MIS_OP_CLR_BIT: mem[bt] = 1'b0;
      MIS_OP_WDT_CLR: {power_down_flag, to, p1, p2, wdt} = 12'h000;
      MIS_OP_WDT_PRE1, MIS_OP_WDT_PRE2: begin
        if (op == MIS_OP_WDT_PRE1) p1 = 1'b1;
        else p2 = 1'b1;
        if (p1 && p2) {power_down_flag, to, p1, p2, wdt} = 12'h000;
      end
      MIS_OP_CPL: mem = ~mem;
      MIS_OP_COMPLEMENT_TO_ACC_OP: acc = ~mem;
      MIS_OP_DAA: begin
        a1 = (acc[3:0] > 4'h9 || ac) ? !ac : 1'b0;
        lo = (acc[3:0] > 4'h9 || ac) ? acc[3:0] + 4'h6 : acc[3:0];
        hi = {1'b0, acc[7:4]} + {4'h0, a1};
        mem = {(hi > 5'h09 || c) ? hi[3:0] + 4'h6 : hi[3:0], lo};
        c = c | (hi > 5'h09);
      end
      MIS_OP_DEC: mem = mem - 8'h01;
      MIS_OP_DECREMENT_TO_ACC_OP: acc = mem - 8'h01;
      MIS_OP_INC: mem = mem + 8'h01;
      MIS_OP_INCREMENT_TO_ACC_OP: acc = mem + 8'h01;
      MIS_OP_HALT: {power_down_flag, to, wdt} = 10'h200;
      MIS_OP_JMP: pc = im;
      MIS_OP_MOV_AM: acc = mem;
      MIS_OP_MOV_MA: mem = acc;
      MIS_OP_MOV_AX: acc = im[7:0];
      MIS_OP_OR_AM: acc = acc | mem;
      MIS_OP_OR_AX: acc = acc | im[7:0];
      MIS_OP_ORM: mem = acc | mem;
      MIS_OP_RET, MIS_OP_RET_AX, MIS_OP_INTERRUPT_RETURN_OP: pc = stk;
      default: ;
    endcase
    if (op == MIS_OP_RET_AX) acc = im[7:0];
    if (op == MIS_OP_INTERRUPT_RETURN_OP) gie = 1'b1;
    case (op)
      MIS_OP_CPL, MIS_OP_DEC, MIS_OP_INC, MIS_OP_ORM: z = (mem == 8'h00);
      MIS_OP_COMPLEMENT_TO_ACC_OP, MIS_OP_DECREMENT_TO_ACC_OP, MIS_OP_INCREMENT_TO_ACC_OP, MIS_OP_OR_AM, MIS_OP_OR_AX: z = (acc == 8'h00);
      default: ;
    endcase
  endtask

  task automatic do_op(input logic [4:0] op);
    logic [31:0] r;
    r = rnd();
    wr(MIS_ADDR_MEM, {24'h0, r[7:0]}, MIS_RESP_OKAY);
    wr(MIS_ADDR_ACC, {24'h0, r[15:8]}, MIS_RESP_OKAY);
    wr(MIS_ADDR_STATUS, {26'h0, r[21], 2'b00, r[18:16]}, MIS_RESP_OKAY);
    wr(MIS_ADDR_STACK, {20'h0, r[31:20]}, MIS_RESP_OKAY);
    {acc, mem, z, ac, c, gie, stk} = {r[15:0], r[18:16], r[21], r[31:20]};
    r = rnd();
    wr(MIS_ADDR_WDT, {24'h0, r[23:16]}, MIS_RESP_OKAY);
    wdt = r[23:16];
    wr(MIS_ADDR_CMD, {4'h0, r[11:0], 5'h0, r[14:12], 3'h0, op}, MIS_RESP_OKAY);
    model(op, r[14:12], r[11:0]);
    if (op == MIS_OP_JMP || op >= MIS_OP_RET) begin
      wr(MIS_ADDR_CMD, 32'h0, MIS_RESP_SLVERR);
    end
    if (op == MIS_OP_HALT) begin
      wait_cs(1'b1);
      wr(MIS_ADDR_CMD, 32'h0, MIS_RESP_SLVERR);
      wake <= 1'b1;
      wait_cs(1'b0);
      wake <= 1'b0;
    end
    for (int n = 0; n < 30; n++) begin
      rd(MIS_ADDR_STATUS, 32'h0, 32'h0, MIS_RESP_OKAY);
      if (rq[MIS_ST_BUSY] === 1'b0) break;
      if (n == 29) tmo();
    end
    rd(MIS_ADDR_ACC, {24'h0, acc}, 32'hff, MIS_RESP_OKAY);
    rd(MIS_ADDR_MEM, {24'h0, mem}, 32'hff, MIS_RESP_OKAY);
    rd(MIS_ADDR_WDT, {24'h0, wdt}, 32'hff, MIS_RESP_OKAY);
    rd(MIS_ADDR_PC, {20'h0, pc}, 32'hfff, MIS_RESP_OKAY);
    rd(MIS_ADDR_STATUS, {23'h0, p2, p1, 1'b0, gie, to, power_down_flag, z, ac, c}, 32'h1ff,
       MIS_RESP_OKAY);
    $display("op %0d done", op);
  endtask

  // ***********************
  // main sequence
  // ***********************
  initial begin
    int j;
    {acc, mem, stk, c, ac, z, power_down_flag, to, gie, p1, p2} = '0;
    pc = MIS_PC_RESET;
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    rd(MIS_ADDR_PC, {20'h0, MIS_PC_RESET}, 32'hfff, MIS_RESP_OKAY);
    rd(8'h1c, 32'h0, 32'hffffffff, MIS_RESP_SLVERR);
    wr(MIS_ADDR_CMD, 32'h18, MIS_RESP_SLVERR);
    // unknown op is refused but still steps pc
    pc = pc + 12'h001;
    do_op(MIS_OP_WDT_CLR);
    for (int i = 0; i < 48; i++) begin
      j = (i < 24) ? i : 47 - i;
      do_op(j[4:0]);
    end
    wrap_up();
  end
endmodule
